//--- sfr_map.svh
// register offsets, field positions, reset values and timing counts
`ifndef SFR_MAP_SVH
`define SFR_MAP_SVH
`define SFR_OFS_CTRL 4'h0
`define SFR_OFS_VOL 4'h4
`define SFR_OFS_STAT 4'h8
`define SFR_OFS_CNT 4'hc
`define SFR_CTRL_WEL_SET 0
`define SFR_CTRL_OP_START 1
`define SFR_CTRL_SUS_SET 2
`define SFR_CTRL_SUS_CLR 3
`define SFR_STAT_BUSY 0
`define SFR_STAT_WEL 1
`define SFR_STAT_SUS 2
`define SFR_STAT_ARMED 3
`define SFR_STAT_RECOVER 4
`define SFR_VOL_RST 19'h00000
`define SFR_OP_ARM 8'h66
`define SFR_OP_RESET 8'h99
`define SFR_RST_TIME_NS 30000
`define SFR_CLK_PERIOD_NS 100
`define SFR_RST_CYCLES ((`SFR_RST_TIME_NS + `SFR_CLK_PERIOD_NS - 1) / `SFR_CLK_PERIOD_NS)
`define SFR_OP_CYCLES 1000
`define SFR_RESP_OKAY 2'h0
`define SFR_RESP_SLVERR 2'h2
`endif

//--- sfr_pkg.sv
// types for the soft reset sequencer
package sfr_pkg;
  typedef enum logic [2:0] {
    SFR_IDLE = 3'b001,
    SFR_ARMED = 3'b010,
    SFR_RECOVER = 3'b100
  } sfr_state_e;
  typedef struct packed {
    logic [7:0] status_bits;
    logic [2:0] wrap_setting_bits;
    logic [7:0] read_parameter_bits;
  } sfr_vol_s;
endpackage

//--- sfr_soft_reset.sv
// software reset command handling with axi4-lite register access
// What this block does
// - a device reset happens only when arming code 66h is directly followed by reset code 99h.
// - any instruction other than 99h or 66h after 66h disarms, so a fresh pair is needed; a repeated 66h stays armed.
// - an accepted reset aborts every internal operation and returns to the power-on state.
// - the reset clears volatile status, write enable latch, suspend, read parameters and wrap bits.
// - after a reset no serial instruction is accepted for a recovery time of about 30 us; CTRL register writes are still accepted.
// - busy reads one from the start of an erase, program or status write cycle until it completes, also while suspended, else zero.
//
// The address map and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`include "sfr_map.svh"
module sfr_soft_reset
  import sfr_pkg::*;
#(
  parameter int RST_CYCLES = `SFR_RST_CYCLES,
  parameter int OP_CYCLES = `SFR_OP_CYCLES
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic spi_cs_n,
  input wire logic spi_sclk,
  input wire logic spi_mosi,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic dev_reset_pulse,
  output logic busy,
  output logic recovering
);
  // byte lane merge for partial writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  sfr_state_e state_ff, nxt_state;
  sfr_vol_s vol_ff;
  logic sclk_q_ff;
  logic [7:0] shift_ff;
  logic [2:0] bit_cnt_ff;
  logic [15:0] rec_cnt_ff;
  logic [15:0] op_cnt_ff;
  logic wel_ff;
  logic sus_ff;
  logic busy_ff;
  logic [15:0] rst_count_ff;
  logic dev_rst_ff;
  logic awready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;

  // serial side: opcode capture on sampled clock rise inside a frame
  wire sclk_rise = spi_sclk && !sclk_q_ff && !spi_cs_n;
  wire [7:0] opcode = {shift_ff[6:0], spi_mosi};
  wire op_done = sclk_rise && (bit_cnt_ff == 3'h7);
  wire is_arm = (opcode == `SFR_OP_ARM);
  wire is_reset = (opcode == `SFR_OP_RESET);
  wire rec_done = (rec_cnt_ff == 16'(RST_CYCLES - 1));
  wire do_reset = (state_ff == SFR_ARMED) && op_done && is_reset;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      SFR_IDLE: begin
        if (op_done && is_arm) begin
          nxt_state = SFR_ARMED;
        end
      end
      SFR_ARMED: begin
        if (op_done) begin
          nxt_state = is_reset ? SFR_RECOVER : (is_arm ? SFR_ARMED : SFR_IDLE);
        end
      end
      SFR_RECOVER: begin
        if (rec_done) begin
          nxt_state = SFR_IDLE;
        end
      end
      default: nxt_state = SFR_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_ff <= SFR_IDLE;
      sclk_q_ff <= 1'b0;
      shift_ff <= 8'h00;
      bit_cnt_ff <= 3'h0;
      rec_cnt_ff <= 16'h0000;
    end else begin
      state_ff <= nxt_state;
      sclk_q_ff <= spi_sclk;
      if (spi_cs_n) begin
        bit_cnt_ff <= 3'h0;
      end else if (sclk_rise) begin
        shift_ff <= opcode;
        bit_cnt_ff <= bit_cnt_ff + 3'h1;
      end
      rec_cnt_ff <= (state_ff == SFR_RECOVER) ? rec_cnt_ff + 16'h0001 : 16'h0000;
    end
  end

  // register write decode
  wire [1:0] idx_ctrl = 2'(`SFR_OFS_CTRL >> 2);
  wire [1:0] idx_vol = 2'(`SFR_OFS_VOL >> 2);
  wire [1:0] idx_stat = 2'(`SFR_OFS_STAT >> 2);
  wire [1:0] idx_cnt = 2'(`SFR_OFS_CNT >> 2);
  wire wr_fire = awready_ff;
  wire wr_ctrl = wr_fire && (s_axi_awaddr[3:2] == idx_ctrl) && s_axi_wstrb[0];
  wire wr_vol = wr_fire && (s_axi_awaddr[3:2] == idx_vol);
  wire wr_ok = (s_axi_awaddr[3:2] == idx_ctrl) || (s_axi_awaddr[3:2] == idx_vol);
  wire op_start = wr_ctrl && s_axi_wdata[`SFR_CTRL_OP_START] && wel_ff && !busy_ff;
  wire [31:0] vol_word = {13'h0000, vol_ff};
  wire [31:0] vol_merged = merge(vol_word, s_axi_wdata, s_axi_wstrb);

  always_ff @(posedge clk) begin
    if (srst || dev_rst_ff) begin
      vol_ff <= `SFR_VOL_RST;
      wel_ff <= 1'b0;
      sus_ff <= 1'b0;
      busy_ff <= 1'b0;
      op_cnt_ff <= 16'h0000;
    end else begin
      if (wr_vol) begin
        vol_ff <= vol_merged[18:0];
      end
      if (op_start) begin
        wel_ff <= 1'b0;
      end else if (wr_ctrl && s_axi_wdata[`SFR_CTRL_WEL_SET]) begin
        wel_ff <= 1'b1;
      end
      if (wr_ctrl && s_axi_wdata[`SFR_CTRL_SUS_SET] && busy_ff) begin
        sus_ff <= 1'b1;
      end else if (wr_ctrl && s_axi_wdata[`SFR_CTRL_SUS_CLR]) begin
        sus_ff <= 1'b0;
      end
      if (op_start) begin
        busy_ff <= 1'b1;
        op_cnt_ff <= 16'h0000;
      end else if (busy_ff && !sus_ff) begin
        op_cnt_ff <= op_cnt_ff + 16'h0001;
        if (op_cnt_ff == 16'(OP_CYCLES - 1)) begin
          busy_ff <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      dev_rst_ff <= 1'b0;
      rst_count_ff <= 16'h0000;
    end else begin
      dev_rst_ff <= do_reset;
      if (do_reset) begin
        rst_count_ff <= rst_count_ff + 16'h0001;
      end
    end
  end

  // axi4-lite slave
  wire aw_take = s_axi_awvalid && s_axi_wvalid && !awready_ff && !bvalid_ff;
  wire ar_take = s_axi_arvalid && !arready_ff && !rvalid_ff;
  wire [4:0] stat_word = {state_ff == SFR_RECOVER, state_ff == SFR_ARMED, sus_ff, wel_ff,
                          busy_ff};
  wire [1:0] ra = s_axi_araddr[3:2];
  wire [31:0] rd_mux = (ra == idx_vol) ? vol_word :
                       (ra == idx_stat) ? {27'h0000000, stat_word} :
                       (ra == idx_cnt) ? {16'h0000, rst_count_ff} : 32'h00000000;
  wire rd_ok = (ra != idx_ctrl);

  always_ff @(posedge clk) begin
    if (srst) begin
      awready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `SFR_RESP_OKAY;
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rresp_ff <= `SFR_RESP_OKAY;
      rdata_ff <= 32'h00000000;
    end else begin
      awready_ff <= aw_take;
      if (wr_fire) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_ok ? `SFR_RESP_OKAY : `SFR_RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
      arready_ff <= ar_take;
      if (arready_ff) begin
        rvalid_ff <= 1'b1;
        rdata_ff <= rd_mux;
        rresp_ff <= rd_ok ? `SFR_RESP_OKAY : `SFR_RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = awready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign dev_reset_pulse = dev_rst_ff;
  assign busy = busy_ff;
  assign recovering = (state_ff == SFR_RECOVER);
endmodule

//--- sfr_soft_reset_asserts.sv
// checker for the soft reset sequencer
`timescale 1ns/1ps
module sfr_soft_reset_asserts #(
  parameter int RST_CYCLES = 300
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_wready,
  input wire logic dev_reset_pulse,
  input wire logic busy,
  input wire logic recovering
);
  int rec_ff;
  always_ff @(posedge clk) rec_ff <= recovering ? rec_ff + 1 : 0;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  property p_rec; dev_reset_pulse |-> ##[0:1] recovering; endproperty
  a_rec: assert property (p_rec) else $error("no recovery");
  property p_abort; dev_reset_pulse |-> ##[1:2] !busy; endproperty
  a_abort: assert property (p_abort) else $error("busy kept");
  property p_len; $fell(recovering) |-> rec_ff == RST_CYCLES; endproperty
  a_len: assert property (p_len) else $error("recovery length");
  property p_quiet; dev_reset_pulse |=> !dev_reset_pulse [*8]; endproperty
  a_quiet: assert property (p_quiet) else $error("reset repeated");
  property p_busy; $rose(busy) |-> $past(s_axi_wready); endproperty
  a_busy: assert property (p_busy) else $error("busy cause");
  property p_por; disable iff (1'b0) srst |=> !recovering && !busy; endproperty
  a_por: assert property (p_por) else $error("reset state");
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_bhold: assert property (p_bhold) else $error("bvalid dropped");
endmodule
bind sfr_soft_reset sfr_soft_reset_asserts #(.RST_CYCLES(RST_CYCLES)) u_chk (.clk(clk),
  .srst(srst), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_wready(s_axi_wready), .dev_reset_pulse(dev_reset_pulse), .busy(busy),
  .recovering(recovering));

//--- sfr_spi_host.sv
// spi host issuing flash instructions
`timescale 1ns/1ps
module sfr_spi_host (
  input wire logic clk,
  output logic cs_n,
  output logic sclk,
  output logic mosi
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    mosi = 1'b1;
  end
  // one opcode per frame, msb first, clock still outside frames
  task automatic send(input logic [7:0] op);
    for (int i = 7; i >= 0; i--) begin
      @(posedge clk);
      cs_n <= 1'b0;
      sclk <= 1'b0;
      mosi <= op[i];
      @(posedge clk);
      sclk <= 1'b1;
    end
    @(posedge clk);
    sclk <= 1'b0;
    cs_n <= 1'b1;
    mosi <= ~op[0];
    @(posedge clk);
  endtask
endmodule

//--- sfr_soft_reset_test.sv
// bench for the soft reset sequencer
`timescale 1ns/1ps
module sfr_soft_reset_test;
  logic clk = 1'b0, srst = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0] bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid, pulse, busy, rec, cs_n, sclk, mosi;
  int mismatches = 0, samples_checked = 0, m_cnt = 0, pulses = 0, n, seed, m_vol;
  initial forever #50 clk = ~clk;
  always @(posedge clk) if (pulse === 1'b1) pulses++;
  sfr_spi_host host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .mosi(mosi));
  sfr_soft_reset #(.RST_CYCLES(100), .OP_CYCLES(20)) uut (.clk(clk), .srst(srst),
    .spi_cs_n(cs_n), .spi_sclk(sclk), .spi_mosi(mosi), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .dev_reset_pulse(pulse), .busy(busy), .recovering(rec));
  task automatic check(input logic [33:0] got, input logic [33:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic tick();
    @(posedge clk);
    if (++n > 200) begin
      mismatches++;
      end_sim();
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do tick(); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do tick(); while (bvalid !== 1'b1);
    bready <= 1'b0;
    check({bresp, 32'h0}, {er, 32'h0});
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do tick(); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do tick(); while (rvalid !== 1'b1);
    rready <= 1'b0;
    check({rresp, rdata}, {er, ed});
  endtask
  initial begin
    seed = $urandom(4);
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    rd(4'h8, 32'h0, 2'h0);
    wr(4'hc, 32'h1, 2'h2);
    rd(4'h0, 32'h0, 2'h2);
    m_vol = $urandom & 32'h7ffff;
    wr(4'h4, m_vol, 2'h0);
    rd(4'h4, m_vol, 2'h0);
    wstrb <= 4'h1;
    wr(4'h4, 32'h000000a5, 2'h0);
    rd(4'h4, {m_vol[31:8], 8'ha5}, 2'h0);
    wstrb <= 4'he;
    wr(4'h0, 32'h1, 2'h0);
    rd(4'h8, 32'h0, 2'h0);
    wstrb <= 4'hf;
    $display("registers done");
    host.send(8'h99);
    host.send(8'h66);
    rd(4'h8, 32'h8, 2'h0);
    host.send(8'h05);
    host.send(8'h99);
    rd(4'h8, 32'h0, 2'h0);
    check(34'(pulses), 34'(m_cnt));
    $display("pairing done");
    wr(4'h0, 32'h1, 2'h0);
    wr(4'h0, 32'h2, 2'h0);
    wr(4'h0, 32'h5, 2'h0);
    rd(4'h8, 32'h7, 2'h0);
    host.send(8'h66);
    host.send(8'h99);
    m_cnt++;
    rd(4'h8, 32'h10, 2'h0);
    rd(4'h4, 32'h0, 2'h0);
    host.send(8'h66);
    host.send(8'h99);
    rd(4'hc, 32'h1, 2'h0);
    n = 0;
    while (rec !== 1'b0) tick();
    rd(4'h8, 32'h0, 2'h0);
    host.send(8'h66);
    host.send(8'h99);
    m_cnt++;
    rd(4'hc, 32'(m_cnt), 2'h0);
    check(34'(pulses), 34'(m_cnt));
    $display("reset done");
    end_sim();
  end
endmodule
